/* File: core/dbas_mem.v */
// Purpose: Data memory, 4096 bytes, registered read data.
// Assumes: One read and one write port on pclk.
// Notes:   Read data lag the address by one cycle.
`timescale 1ns/1ps
`include "dbas_consts.vh"

module dbas_mem (
  input  wire        pclk,
  input  wire        we,
  input  wire [11:0] waddr,
  input  wire [7:0]  wdata,
  input  wire [11:0] raddr,
  output reg  [7:0]  rdata
);
  reg [7:0] mem [0:`DBAS_MEM_DEPTH-1];

  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // dbas_mem

/* File: core/dbas_top.v */
// Purpose: Direct data address formation with bank select and access window.
// Assumes: APB slave, pclk 10 MHz, presetn async active low.
// Notes:   Software drives decoder-style commands through registers.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "dbas_consts.vh"

module dbas_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [11:0] data_addr,
  output reg         bank_unimpl
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RD   = 4'b0010;
  localparam [3:0] ST_MV   = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg  [3:0]  state;
  reg  [7:0]  bank_select;
  reg  [8:0]  file_addr;     // [8] is access bit, [7:0] file address
  reg  [23:0] move_addr;     // [23:12] source, [11:0] destination
  reg  [7:0]  wdata_reg;
  reg  [7:0]  result;
  reg  [4:0]  flags;         // N OV Z DC C
  reg  [15:0] impl_banks;
  reg         busy;
  reg         mv_pending;    // A move is in flight, not a plain read
  reg         mem_we;
  reg  [11:0] mem_waddr;
  reg  [7:0]  mem_wdata;
  reg  [11:0] mem_raddr;
  wire [7:0]  mem_rdata;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  function [11:0] form_addr;
    input       access;
    input [7:0] faddr;
    input [7:0] bsel;
    begin
      if (!access) begin
        // Low half goes to bank 0, high half to the SFR bank
        if (faddr < `DBAS_ACCESS_SPLIT)
          form_addr = {`DBAS_RAM_BANK0, faddr};
        else
          form_addr = {`DBAS_SFR_BANK, faddr};
      end else begin
        form_addr = {bsel[3:0], faddr};
      end
    end
  endfunction

  function impl_ok;
    input [11:0] a;
    input [15:0] map;
    begin
      impl_ok = map[a[11:8]];
    end
  endfunction

  wire        acc_bit   = file_addr[8];
  wire [11:0] dir_addr  = form_addr(acc_bit, file_addr[7:0], bank_select);
  wire        dir_impl  = impl_ok(dir_addr, impl_banks);
  wire [11:0] mv_src    = move_addr[23:12];
  wire [11:0] mv_dst    = move_addr[11:0];
  wire        src_impl  = impl_ok(mem_raddr, impl_banks);

  wire setup_wr = psel & ~penable & pwrite;
  wire acc_wr   = psel & penable & pwrite;
  wire acc_rd   = psel & penable & ~pwrite;
  wire [2:0] cmd = pwdata[2:0];
  wire cmd_go   = acc_wr && paddr == `DBAS_OFF_CMD && !busy;

  // Flags from the loaded or written value, set even for unimplemented banks
  function [4:0] calc_flags;
    input [7:0] v;
    begin
      calc_flags = {v[7], 1'b0, (v == 8'h00), 1'b0, 1'b0};
    end
  endfunction

  dbas_mem u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      bank_select <= `DBAS_BSEL_RESET;
      file_addr   <= 9'h000;
      move_addr   <= 24'h000000;
      wdata_reg   <= 8'h00;
      result      <= 8'h00;
      flags       <= 5'h00;
      impl_banks  <= `DBAS_IMPL_RESET;
      busy        <= 1'b0;
      mv_pending  <= 1'b0;
      mem_we      <= 1'b0;
      mem_waddr   <= 12'h000;
      mem_wdata   <= 8'h00;
      mem_raddr   <= 12'h000;
      data_addr   <= 12'h000;
      bank_unimpl <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      if (acc_wr && !busy) begin
        case (paddr)
          `DBAS_OFF_BANK_SELECT: bank_select <= pwdata[7:0] & `DBAS_BSEL_MASK;
          `DBAS_OFF_FILE_ADDR:   file_addr   <= pwdata[8:0];
          `DBAS_OFF_MOVE_ADDR:   move_addr   <= pwdata[23:0];
          `DBAS_OFF_WDATA:       wdata_reg   <= pwdata[7:0];
          `DBAS_OFF_IMPL:        impl_banks  <= pwdata[15:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            case (cmd)
              `DBAS_CMD_READ: begin
                mem_raddr   <= dir_addr;
                data_addr   <= dir_addr;
                bank_unimpl <= ~dir_impl;
                busy        <= 1'b1;
                state       <= ST_RD;
              end
              `DBAS_CMD_WRITE: begin
                data_addr   <= dir_addr;
                bank_unimpl <= ~dir_impl;
                mem_we      <= dir_impl;
                mem_waddr   <= dir_addr;
                mem_wdata   <= wdata_reg;
                flags       <= calc_flags(wdata_reg);
              end
              `DBAS_CMD_MOVE: begin
                mem_raddr   <= mv_src;
                data_addr   <= mv_src;
                bank_unimpl <= ~impl_ok(mv_src, impl_banks);
                mv_pending  <= 1'b1;
                busy        <= 1'b1;
                state       <= ST_MV;
              end
              `DBAS_CMD_LOADBANK:
                bank_select <= pwdata[15:8] & `DBAS_BSEL_MASK;
              default: ;
            endcase
          end
        end
        ST_RD: begin
          state <= ST_DONE;
        end
        ST_MV: begin
          state <= ST_DONE;
        end
        ST_DONE: begin
          if (!mv_pending) begin
            if (src_impl) begin
              result <= mem_rdata;
              flags  <= calc_flags(mem_rdata);
            end else begin
              result <= 8'h00;
              flags  <= calc_flags(8'h00);
            end
          end else begin
            // Keyed on the command, not on address matches, so a read never copies
            // An unimplemented source reads as zero; an unimplemented target drops it
            mem_we    <= impl_ok(mv_dst, impl_banks);
            mem_waddr <= mv_dst;
            mem_wdata <= src_impl ? mem_rdata : 8'h00;
          end
          mv_pending <= 1'b0;
          busy       <= 1'b0;
          state      <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `DBAS_OFF_BANK_SELECT: prdata <= {24'h000000, bank_select};
          `DBAS_OFF_FILE_ADDR:   prdata <= {23'h000000, file_addr};
          `DBAS_OFF_MOVE_ADDR:   prdata <= {8'h00, move_addr};
          `DBAS_OFF_WDATA:       prdata <= {24'h000000, wdata_reg};
          `DBAS_OFF_RESULT:      prdata <= {24'h000000, result};
          `DBAS_OFF_STATUS:      prdata <= {13'h0000, data_addr, bank_unimpl, busy, flags};
          `DBAS_OFF_IMPL:        prdata <= {16'h0000, impl_banks};
          `DBAS_OFF_CMD:         prdata <= 32'h00000000;
          default:               pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // dbas_top

/* File: include/dbas_consts.vh */
// Purpose: Constants for the data bank address select block.
// Assumes: APB register map, 32-bit data, byte addresses.
// Notes:   Register offsets here are local choices.
// Operation
// - Access window is low 128 bytes of bank 0 plus high 128 of bank 15
// - One access bit picks bank-select register or access window
// - With access bit zero, last low byte is followed by first high byte
// - Special function registers sit in high access region, reachable from any bank
// - Data memory is split into sixteen banks for direct addressing
// - Top four address bits come from low nibble of bank select
// - Upper four bank-select bits read zero and ignore writes
// - Unimplemented bank reads zero and ignores writes
// - Status flags update normally even for unimplemented banks
// - Each bank decodes 256 byte locations, offsets up to FFh
// - File-to-file move ignores bank select, uses full 12-bit addresses
// - Load-bank-literal op writes a constant into bank select
`ifndef DBAS_CONSTS_VH
`define DBAS_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DBAS_OFF_BANK_SELECT 12'h000
`define DBAS_OFF_CMD         12'h004
`define DBAS_OFF_FILE_ADDR   12'h008
`define DBAS_OFF_MOVE_ADDR   12'h00C
`define DBAS_OFF_WDATA       12'h010
`define DBAS_OFF_RESULT      12'h014
`define DBAS_OFF_STATUS      12'h018
`define DBAS_OFF_IMPL        12'h01C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DBAS_BSEL_RESET      8'h00
`define DBAS_BSEL_MASK       8'h0F
`define DBAS_IMPL_RESET      16'h0003
`define DBAS_ACCESS_SPLIT    8'h80
`define DBAS_SFR_BANK        4'hF
`define DBAS_RAM_BANK0       4'h0
`define DBAS_CMD_READ        3'h1
`define DBAS_CMD_WRITE       3'h2
`define DBAS_CMD_MOVE        3'h3
`define DBAS_CMD_LOADBANK    3'h4
`define DBAS_CMD_BIT_ACCESS  3
`define DBAS_MEM_DEPTH       4096

`endif

/* File: sim/dbas_dec_model.sv */
// Purpose: Decoder-side bus master that drives the block's registers.
// Assumes: One transfer at a time, called from the bench.
// Notes:   Released address and data are inverted so stale values never pass.
`timescale 1ns/1ps
module dbas_dec_model (
  input  wire        pclk,
  input  wire        pready,
  input  wire        pslverr,
  input  wire [31:0] prdata,
  output reg         psel = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite = 1'b0,
  output reg  [11:0] paddr = 12'h000,
  output reg  [31:0] pwdata = 32'h0
);
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
    end
  endtask
endmodule // dbas_dec_model

/* File: sim/dbas_top_asserts.sv */
// Purpose: Port checks for the bank address select block.
// Assumes: No register write is issued while the block is busy.
// Notes:   Helper copies mirror what software last wrote.
`timescale 1ns/1ps
`include "dbas_consts.vh"
module dbas_top_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] data_addr,
  input wire        bank_unimpl
);
  reg  [3:0]  bsel_q;
  reg  [8:0]  fa_q;
  reg  [2:0]  cmd_q;
  reg  [15:0] impl_q;
  wire        wr_ok = psel && penable && pready && pwrite;
  wire        rd_bs = pready && !pwrite && paddr == `DBAS_OFF_BANK_SELECT;
  wire        op_rw = cmd_q == `DBAS_CMD_READ || cmd_q == `DBAS_CMD_WRITE;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsel_q <= 4'h0;
      fa_q   <= 9'h000;
      cmd_q  <= 3'h0;
      impl_q <= `DBAS_IMPL_RESET;
    end else if (wr_ok) begin
      case (paddr)
        `DBAS_OFF_BANK_SELECT: bsel_q <= pwdata[3:0];
        `DBAS_OFF_FILE_ADDR:   fa_q <= pwdata[8:0];
        `DBAS_OFF_IMPL:        impl_q <= pwdata[15:0];
        `DBAS_OFF_CMD: begin
          cmd_q <= pwdata[2:0];
          if (pwdata[2:0] == `DBAS_CMD_LOADBANK) bsel_q <= pwdata[11:8];
        end
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  error_read_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  bank_upper_zero_a: assert property (rd_bs |-> prdata[31:4] == 28'h0)
    else $error("bank select upper bits not zero");
  bank_readback_a: assert property (rd_bs |-> prdata[3:0] == bsel_q)
    else $error("bank select readback wrong");
  access_window_a: assert property (
    $changed(data_addr) && op_rw && !fa_q[8] |->
    data_addr == {fa_q[7] ? `DBAS_SFR_BANK : `DBAS_RAM_BANK0, fa_q[7:0]})
    else $error("access window address wrong");
  bank_path_a: assert property (
    $changed(data_addr) && op_rw && fa_q[8] |-> data_addr == {bsel_q, fa_q[7:0]})
    else $error("banked address wrong");
  unimpl_flag_a: assert property (
    $changed(data_addr) && op_rw |-> bank_unimpl == !impl_q[data_addr[11:8]])
    else $error("unimplemented bank flag wrong");
endmodule // dbas_top_chk

/* File: sim/tb_data_bank_address_select.sv */
// Purpose: Self-checking bench for the bank address select block.
// Assumes: Memory is only read where the bench wrote it first.
// Notes:   Rows hold bank, file address, data, address and flag.
`timescale 1ns/1ps
`include "dbas_consts.vh"
module tb_data_bank_address_select;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr, bank_unimpl;
  wire [11:0] paddr, data_addr;
  wire [31:0] pwdata, prdata;
  reg  [31:0] r;
  reg         e;
  reg  [7:0]  x;
  reg  [37:0] rows [0:4];
  integer     failures = 0;
  integer     n_compared = 0;
  integer     i, k;
  always #50 pclk = ~pclk;
  dbas_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .data_addr, .bank_unimpl);
  dbas_dec_model i_dec (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  task chk(input [31:0] g, input [31:0] w);
    begin
      n_compared = n_compared + 1;
      if (g !== w) begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, w);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    i_dec.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input [11:0] a);
    i_dec.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task cmd(input [2:0] c, input [7:0] lit);
    begin
      wr(`DBAS_OFF_CMD, {16'h0, lit, 5'h0, c});
      rd(`DBAS_OFF_STATUS);
      for (k = 0; r[5] !== 1'b0 && k < 50; k = k + 1) rd(`DBAS_OFF_STATUS);
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #500000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    rows[0] = {8'h00, 9'h07F, 8'hA5, 12'h07F, 1'b0};
    rows[1] = {8'h00, 9'h080, 8'h3C, 12'hF80, 1'b0};
    rows[2] = {8'h01, 9'h1FF, 8'h00, 12'h1FF, 1'b0};
    rows[3] = {8'h25, 9'h100, 8'h77, 12'h500, 1'b1};
    rows[4] = {8'h0F, 9'h180, 8'hC1, 12'hF80, 1'b0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DBAS_OFF_BANK_SELECT);
    chk(r, 32'h0);
    rd(`DBAS_OFF_IMPL);
    chk(r, 32'h3);
    rd(12'h020);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    wr(`DBAS_OFF_IMPL, 32'h8003);
    for (i = 0; i < 5; i = i + 1) begin
      x = rows[i][0] ? 8'h00 : rows[i][20:13];
      wr(`DBAS_OFF_BANK_SELECT, 32'(rows[i][37:30]));
      rd(`DBAS_OFF_BANK_SELECT);
      chk(r, 32'(rows[i][33:30]));
      wr(`DBAS_OFF_FILE_ADDR, 32'(rows[i][29:21]));
      wr(`DBAS_OFF_WDATA, 32'(rows[i][20:13]));
      cmd(`DBAS_CMD_WRITE, 8'h00);
      chk(32'(data_addr), 32'(rows[i][12:1]));
      chk(32'(bank_unimpl), 32'(rows[i][0]));
      cmd(`DBAS_CMD_READ, 8'h00);
      rd(`DBAS_OFF_RESULT);
      chk(r, 32'(x));
      rd(`DBAS_OFF_STATUS);
      chk(32'(r[4:0]), 32'({x[7], 1'b0, x == 8'h00, 2'b00}));
    end
    wr(`DBAS_OFF_FILE_ADDR, 32'h080);
    cmd(`DBAS_CMD_READ, 8'h00);
    rd(`DBAS_OFF_RESULT);
    chk(r, 32'hC1);
    cmd(`DBAS_CMD_LOADBANK, 8'hF3);
    rd(`DBAS_OFF_BANK_SELECT);
    chk(r, 32'h3);
    wr(`DBAS_OFF_MOVE_ADDR, {8'h00, 12'h07F, 12'h1FE});
    cmd(`DBAS_CMD_MOVE, 8'h00);
    wr(`DBAS_OFF_BANK_SELECT, 32'h1);
    wr(`DBAS_OFF_FILE_ADDR, 32'h1FE);
    cmd(`DBAS_CMD_READ, 8'h00);
    rd(`DBAS_OFF_RESULT);
    chk(r, 32'hA5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DBAS_OFF_BANK_SELECT);
    chk(r, 32'h0);
    chk(32'(data_addr), 32'h0);
    end_of_test;
  end
endmodule // tb_data_bank_address_select
bind dbas_top dbas_top_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .data_addr, .bank_unimpl);
